//--- hdl/irqf_cfg.svh
// Offsets, field positions, reset values and counts of the interrupt flag block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IRQF_CFG_SVH
`define IRQF_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define IRQF_IDX_PRIO   12'hfb2
`define IRQF_IDX_MODE0  12'hfb4
`define IRQF_IDX_MODE1  12'hfb5
`define IRQF_IDX_MODEK  12'hfb6
`define IRQF_IDX_BT     12'hfb8
`define IRQF_IDX_WT     12'hfba
`define IRQF_IDX_CM     12'hfbc
`define IRQF_IDX_SER    12'hfbd
`define IRQF_IDX_PINS   12'hfbe
`define IRQF_IDX_KEY    12'hfbf
`define IRQF_PADDR_W    14

// Source numbers, also used as the acknowledge code.
`define IRQF_NSRC       7
`define IRQF_SRC_PIN0   3'h0
`define IRQF_SRC_PIN1   3'h1
`define IRQF_SRC_BT     3'h2
`define IRQF_SRC_SER    3'h3
`define IRQF_SRC_CM     3'h4
`define IRQF_SRC_WT     3'h5
`define IRQF_SRC_KEY    3'h6
`define IRQF_NVECT      3'h5

// Field positions.
`define IRQF_EN_BIT     1
`define IRQF_REQ_BIT    0
`define IRQF_PIN1_EN    3
`define IRQF_PIN1_REQ   2
`define IRQF_PIN0_EN    1
`define IRQF_PIN0_REQ   0
`define IRQF_MODE0_CLK  3
`define IRQF_IME_BIT    3

// Pin 0 trigger encodings.
`define IRQF_TRIG_RISE  2'h0
`define IRQF_TRIG_FALL  2'h1
`define IRQF_TRIG_BOTH  2'h2

// Reset values and counts.
`define IRQF_FLAGS_RST  7'h00
`define IRQF_NIB_RST    4'h0
`define IRQF_DIV64_MAX  6'h3f

`endif

//--- hdl/irqf_pkg.sv
// Types of the interrupt flag block.
// Assumes the constants header is on the include path.
`include "irqf_cfg.svh"

package irqf_pkg;

  typedef struct packed {
    logic [3:0]  pin0_mode;
    logic        pin1_mode;
    logic [2:0]  keys_mode;
    logic [3:0]  prio;
    logic [6:0]  en;
    logic [6:0]  req;
    logic        match_q;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [6:0]  irq;
  } irqf_main_t;

  typedef struct packed {
    logic       primed;
    logic [5:0] div_cnt;
    logic       pin0_q;
    logic       pin1_q;
    logic [2:0] keys_q;
    logic       pin0_edge;
    logic       pin1_edge;
    logic       keys_edge;
  } irqf_edge_t;

endpackage

//--- hdl/irqf_evt_if.sv
// Carrier between the flag registers and the pin edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface irqf_evt_if;
  logic [3:0] pin0_mode;
  logic       pin1_mode;
  logic [2:0] keys_mode;
  logic       pin0_edge;
  logic       pin1_edge;
  logic       keys_edge;

  modport ctl (output pin0_mode, output pin1_mode, output keys_mode,
               input pin0_edge, input pin1_edge, input keys_edge);
  modport det (input pin0_mode, input pin1_mode, input keys_mode,
               output pin0_edge, output pin1_edge, output keys_edge);
endinterface

//--- hdl/irqf_edge.sv
// Samples the external pins and key lines and reports selected edges as pulses.
// Assumes pins are synchronous to pclk and cpu_clk_en is a one-cycle enable.
`timescale 1ns/10ps
`include "irqf_cfg.svh"

module irqf_edge (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic       ext_pin_zero,
  input wire logic       ext_pin_one,
  input wire logic [2:0] key_lines,
  input wire logic       cpu_clk_en,
  // Configuration and events
  irqf_evt_if.det        evt
);

  irqf_pkg::irqf_edge_t q;
  irqf_pkg::irqf_edge_t d;

  function automatic logic edge_hit(input logic [1:0] trig, input logic prev,
                                    input logic cur);
    logic r;
    r = 1'b0;
    case (trig)
      `IRQF_TRIG_RISE: r = !prev && cur;
      `IRQF_TRIG_FALL: r = prev && !cur;
      `IRQF_TRIG_BOTH: r = prev != cur;
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  logic div_tick;
  logic pin0_en;

  always_comb begin
    d = q;
    div_tick = q.div_cnt == `IRQF_DIV64_MAX;
    d.div_cnt = q.div_cnt + 6'h01;
    pin0_en = evt.pin0_mode[`IRQF_MODE0_CLK] ? div_tick : cpu_clk_en; // R15
    d.pin0_edge = 1'b0;
    d.pin1_edge = 1'b0;
    d.keys_edge = 1'b0;
    // The first sample after reset only loads history, so a pin already high
    // at reset does not look like a rising edge.
    d.primed = 1'b1;
    d.pin1_q = ext_pin_one;
    d.keys_q = key_lines;
    if (q.primed) begin
      d.pin1_edge = edge_hit({1'b0, evt.pin1_mode}, q.pin1_q, ext_pin_one); // R18
      for (int i = 0; i < 3; i++) begin
        if (evt.keys_mode[i] && q.keys_q[i] && !key_lines[i]) begin
          d.keys_edge = 1'b1; // R19
        end
      end
    end
    if (pin0_en) begin
      d.pin0_q = ext_pin_zero;
      d.pin0_edge = q.primed &&
                    edge_hit(evt.pin0_mode[1:0], q.pin0_q, ext_pin_zero); // R16
    end else if (!q.primed) begin
      d.pin0_q = ext_pin_zero;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign evt.pin0_edge = q.pin0_edge;
  assign evt.pin1_edge = q.pin1_edge;
  assign evt.keys_edge = q.keys_edge;

endmodule

//--- hdl/irqf_top.sv
// Interrupt request and enable flags with an APB register slave.
// Assumes pins and event strobes are synchronous to pclk; the CPU core
// acknowledges a vectored source with a one-cycle ack_valid and its code.
//
// Functional notes
// R1 - Pin 1 requests are passed on only while its enable flag is one.
// R2 - A selected edge on pin 1 sets its request flag; hardware clears it.
// R3 - Pin 0 requests are passed on only while its enable flag is one.
// R4 - A configured edge on pin 0 sets its request flag; hardware clears it.
// R5 - The key enable flag gates requests from all three key lines.
// R6 - A falling key edge sets the key flag; only software clears it.
// R7 - The basic timer enable flag gates basic timer requests.
// R8 - The basic timer interval signal sets its flag; hardware clears it.
// R9 - The serial enable flag gates serial completion requests.
// R10 - Serial transfer completion sets its flag; hardware clears it.
// R11 - The counter match enable flag gates match requests.
// R12 - Counter equal to reference sets the match flag; hardware clears it.
// R13 - The watch timer enable flag gates watch timer requests.
// R14 - Each watch interval sets the watch flag; only software clears it.
// R15 - Pin 0 mode bit 3 picks CPU clock or system clock over 64 sampling.
// R16 - Pin 0 trigger: rising, falling, both, or never set.
// R17 - All flags reset to zero; unused upper bits read as zero.
// R18 - Pin 1 mode bit 0 picks rising or falling edge.
// R19 - Three key mode bits enable falling detection per line; zero disables.
// R20 - The master enable bit inhibits or permits all interrupt processing.
// R21 - A request is presented only with request, enable and master enable set.
// R22 - Vectored flags clear when the CPU accepts and vectors to that source.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "irqf_cfg.svh"

module irqf_top (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`IRQF_PADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // External pins
  input  wire logic                     ext_pin_zero,
  input  wire logic                     ext_pin_one,
  input  wire logic [2:0]               key_lines,
  input  wire logic                     cpu_clk_en,
  // Peripheral events
  input  wire logic                     basic_timer_interval,
  input  wire logic                     serial_done,
  input  wire logic [7:0]               counter_value,
  input  wire logic [7:0]               counter_reference,
  input  wire logic                     watch_interval,
  // CPU core
  input  wire logic                     ack_valid,
  input  wire logic [2:0]               ack_source,
  output logic [`IRQF_NSRC-1:0]         irq_request,
  output logic [2:0]                    irq_priority_sel
);

  irqf_pkg::irqf_main_t q;
  irqf_pkg::irqf_main_t d;

  irqf_evt_if evt ();

  irqf_edge u_edge (
    .pclk         (pclk),
    .presetn      (presetn),
    .ext_pin_zero (ext_pin_zero),
    .ext_pin_one  (ext_pin_one),
    .key_lines    (key_lines),
    .cpu_clk_en   (cpu_clk_en),
    .evt          (evt.det)
  );

  assign evt.pin0_mode = q.pin0_mode;
  assign evt.pin1_mode = q.pin1_mode;
  assign evt.keys_mode = q.keys_mode;

  function automatic logic idx_hit(input logic [11:0] idx);
    logic r;
    r = 1'b0;
    case (idx)
      `IRQF_IDX_PRIO, `IRQF_IDX_MODE0, `IRQF_IDX_MODE1, `IRQF_IDX_MODEK,
      `IRQF_IDX_BT, `IRQF_IDX_WT, `IRQF_IDX_CM, `IRQF_IDX_SER,
      `IRQF_IDX_PINS, `IRQF_IDX_KEY: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Packs one source's enable and request into the low two bits of a nibble.
  function automatic logic [3:0] pair_nib(input logic en, input logic req);
    return {2'b00, en, req};
  endfunction

  logic [11:0]           idx;
  logic                  acc;
  logic                  wr_go;
  logic                  match_now;
  logic [3:0]            rd_nib;
  logic [`IRQF_NSRC-1:0] set_vec;

  always_comb begin
    d = q;
    idx = paddr[`IRQF_PADDR_W-1:2];
    acc = psel && penable;
    wr_go = acc && q.pready && pwrite && idx_hit(idx);
    match_now = counter_value == counter_reference;
    d.match_q = match_now;

    set_vec = '0;
    set_vec[`IRQF_SRC_PIN0] = evt.pin0_edge; // R4
    set_vec[`IRQF_SRC_PIN1] = evt.pin1_edge; // R2
    set_vec[`IRQF_SRC_BT] = basic_timer_interval; // R8
    set_vec[`IRQF_SRC_SER] = serial_done; // R10
    set_vec[`IRQF_SRC_CM] = match_now && !q.match_q; // R12
    set_vec[`IRQF_SRC_WT] = watch_interval; // R14
    set_vec[`IRQF_SRC_KEY] = evt.keys_edge; // R6

    // Only vectored sources are cleared by acceptance; quasi sources wait
    // for software, so a missed poll never loses a key or watch event.
    if (ack_valid && ack_source < `IRQF_NVECT) begin
      d.req[ack_source] = 1'b0; // R22
    end

    if (wr_go) begin
      case (idx)
        `IRQF_IDX_PRIO:  d.prio = pwdata[3:0];
        `IRQF_IDX_MODE0: d.pin0_mode = {pwdata[3], 1'b0, pwdata[1:0]};
        `IRQF_IDX_MODE1: d.pin1_mode = pwdata[0];
        `IRQF_IDX_MODEK: d.keys_mode = pwdata[2:0];
        `IRQF_IDX_BT: begin
          d.en[`IRQF_SRC_BT] = pwdata[`IRQF_EN_BIT];
          d.req[`IRQF_SRC_BT] = pwdata[`IRQF_REQ_BIT];
        end
        `IRQF_IDX_WT: begin
          d.en[`IRQF_SRC_WT] = pwdata[`IRQF_EN_BIT];
          d.req[`IRQF_SRC_WT] = pwdata[`IRQF_REQ_BIT];
        end
        `IRQF_IDX_CM: begin
          d.en[`IRQF_SRC_CM] = pwdata[`IRQF_EN_BIT];
          d.req[`IRQF_SRC_CM] = pwdata[`IRQF_REQ_BIT];
        end
        `IRQF_IDX_SER: begin
          d.en[`IRQF_SRC_SER] = pwdata[`IRQF_EN_BIT];
          d.req[`IRQF_SRC_SER] = pwdata[`IRQF_REQ_BIT];
        end
        `IRQF_IDX_PINS: begin
          d.en[`IRQF_SRC_PIN1] = pwdata[`IRQF_PIN1_EN];
          d.req[`IRQF_SRC_PIN1] = pwdata[`IRQF_PIN1_REQ];
          d.en[`IRQF_SRC_PIN0] = pwdata[`IRQF_PIN0_EN];
          d.req[`IRQF_SRC_PIN0] = pwdata[`IRQF_PIN0_REQ];
        end
        `IRQF_IDX_KEY: begin
          d.en[`IRQF_SRC_KEY] = pwdata[`IRQF_EN_BIT];
          d.req[`IRQF_SRC_KEY] = pwdata[`IRQF_REQ_BIT];
        end
        default: d.prio = q.prio;
      endcase
    end

    // A hardware event in the same cycle as a clear leaves the flag set.
    d.req = d.req | set_vec;

    // Each enable gates its own source; the master enable gates all.
    d.irq = d.req & d.en & {`IRQF_NSRC{d.prio[`IRQF_IME_BIT]}}; // R1 R3 R5 R7 R9 R11 R13 R20 R21

    case (idx)
      `IRQF_IDX_BT:   rd_nib = pair_nib(q.en[`IRQF_SRC_BT], q.req[`IRQF_SRC_BT]); // R17
      `IRQF_IDX_WT:   rd_nib = pair_nib(q.en[`IRQF_SRC_WT], q.req[`IRQF_SRC_WT]);
      `IRQF_IDX_CM:   rd_nib = pair_nib(q.en[`IRQF_SRC_CM], q.req[`IRQF_SRC_CM]);
      `IRQF_IDX_SER:  rd_nib = pair_nib(q.en[`IRQF_SRC_SER], q.req[`IRQF_SRC_SER]);
      `IRQF_IDX_KEY:  rd_nib = pair_nib(q.en[`IRQF_SRC_KEY], q.req[`IRQF_SRC_KEY]);
      `IRQF_IDX_PINS: rd_nib = {q.en[`IRQF_SRC_PIN1], q.req[`IRQF_SRC_PIN1],
                                q.en[`IRQF_SRC_PIN0], q.req[`IRQF_SRC_PIN0]};
      default:        rd_nib = `IRQF_NIB_RST;
    endcase

    // One wait state: pready rises in the second access cycle, with the
    // read data taken from the flags as they stood in the first.
    d.pready = acc && !q.pready;
    if (acc && !q.pready) begin
      d.pslverr = !idx_hit(idx);
      d.prdata = {28'h0000000, pwrite ? `IRQF_NIB_RST : rd_nib};
    end else begin
      d.pslverr = 1'b0;
      d.prdata = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; // R17
    end else begin
      q <= d;
    end
  end

  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;
  assign irq_request = q.irq;
  assign irq_priority_sel = q.prio[2:0];

endmodule

//--- dv/irqf_top_props.sv
// Checker for the interrupt flag block, bound to its top module.
// Assumes it sees the top module's ports only.
`timescale 1ns/10ps

module irqf_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Events and CPU side
  input wire logic        basic_timer_interval,
  input wire logic        serial_done,
  input wire logic        ack_valid,
  input wire logic [2:0]  ack_source,
  input wire logic [6:0]  irq_request,
  input wire logic [2:0]  irq_priority_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A completed write may move any flag, so it excuses the flag checks below.
  wire wr = psel && penable && pready && pwrite;

  a_upper_zero: assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("upper read bits not zero");
  a_bt_cause: assert property ($rose(irq_request[2]) |-> $past(basic_timer_interval)
    || $past(wr) || $past(wr, 2)) else $error("basic timer request without cause");
  a_ser_cause: assert property ($rose(irq_request[3]) |-> $past(serial_done)
    || $past(wr) || $past(wr, 2)) else $error("serial request without cause");
  a_bt_ack: assert property (ack_valid && ack_source == 3'h2 && !basic_timer_interval
    && !wr |=> !irq_request[2]) else $error("basic timer flag not cleared");
  a_pin1_ack: assert property (ack_valid && ack_source == 3'h1 && !wr
    |=> !irq_request[1]) else $error("pin 1 flag not cleared");
  a_watch_kept: assert property (irq_request[5] && !wr && !$past(wr) |=> irq_request[5])
    else $error("watch flag lost");
  a_key_kept: assert property (irq_request[6] && !wr && !$past(wr) |=> irq_request[6])
    else $error("key flag lost");
  a_prio_write: assert property ($changed(irq_priority_sel) |-> $past(wr)
    && $past(paddr) == 14'h3ec8) else $error("priority changed without write");
endmodule

bind irqf_top irqf_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .basic_timer_interval, .serial_done, .ack_valid, .ack_source, .irq_request,
  .irq_priority_sel);

//--- dv/irqf_cpu_model.sv
// CPU core model that accepts one vectored request at a time.
// Assumes the bench raises go while the core may take interrupts.
`timescale 1ns/10ps

module irqf_cpu_model (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Flag block side
  input wire logic       go,
  input wire logic [6:0] irq_request,
  output logic           ack_valid,
  output logic [2:0]     ack_source
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_valid <= 1'b0;
      ack_source <= 3'h7;
    end else if (go && !ack_valid && irq_request[4:0] != 5'h0) begin
      // Quasi sources 5 and 6 are never taken; software must clear them.
      ack_valid <= 1'b1;
      for (int i = 4; i >= 0; i--)
        if (irq_request[i]) ack_source <= 3'(i);
    end else begin
      ack_valid <= 1'b0;
      ack_source <= ~ack_source;
    end
  end
endmodule

//--- dv/irqf_top_bench.sv
// Bench for the flag block: events, pins, keys, acknowledge and registers.
// Assumes the CPU model answers vectored requests while go is high.
`timescale 1ns/10ps
`include "irqf_cfg.svh"

module irqf_top_bench;
  typedef struct {logic [11:0] idx; int k; logic [3:0] w; logic [3:0] rb; logic q;} irqf_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        p0 = 1'b0, p1 = 1'b0, clk_en = 1'b1, bti = 1'b0, sdone = 1'b0;
  logic        wint = 1'b0, go = 1'b0, pready, pslverr, ack_valid, sl;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  keys = 3'h7, ack_source, prio_sel;
  logic [7:0]  cval = 8'h00, cref = 8'h5a;
  logic [6:0]  irq;
  int          err_count = 0, check_count = 0;
  logic [11:0] regs [8] = '{`IRQF_IDX_PRIO, `IRQF_IDX_MODE0, `IRQF_IDX_BT, `IRQF_IDX_WT,
                            `IRQF_IDX_CM, `IRQF_IDX_SER, `IRQF_IDX_PINS, `IRQF_IDX_KEY};
  irqf_row_t   rows [6] = '{'{`IRQF_IDX_BT, 2, 4'h2, 4'h3, 1'b1},
                            '{`IRQF_IDX_BT, 2, 4'h0, 4'h1, 1'b0},
                            '{`IRQF_IDX_SER, 3, 4'h2, 4'h3, 1'b1},
                            '{`IRQF_IDX_CM, 4, 4'h0, 4'h1, 1'b0},
                            '{`IRQF_IDX_CM, 4, 4'h2, 4'h3, 1'b1},
                            '{`IRQF_IDX_WT, 5, 4'h2, 4'h3, 1'b1}};

  always #2 pclk = ~pclk;

  irqf_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .ext_pin_zero(p0), .ext_pin_one(p1), .key_lines(keys), .cpu_clk_en(clk_en),
    .basic_timer_interval(bti), .serial_done(sdone), .counter_value(cval),
    .counter_reference(cref), .watch_interval(wint), .ack_valid, .ack_source,
    .irq_request(irq), .irq_priority_sel(prio_sel));
  irqf_cpu_model cpu (.pclk, .presetn, .go, .irq_request(irq), .ack_valid, .ack_source);

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [11:0] idx, input logic [3:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {28'h0, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    chk("wait states", 2, n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task pulse(input int k);
    case (k)
      2: bti <= 1'b1;
      3: sdone <= 1'b1;
      4: cval <= cref;
      default: wint <= 1'b1;
    endcase
    @(posedge pclk);
    bti <= 1'b0;
    sdone <= 1'b0;
    wint <= 1'b0;
    cval <= 8'h00;
    tick(2);
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    tick(5);
    presetn <= 1'b1;
    tick(1);
    apb(1'b1, `IRQF_IDX_PRIO, 4'hd);
    chk("prio_sel", 3'h5, prio_sel);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].w);
      pulse(rows[i].k);
      chk("irq", rows[i].q, irq[rows[i].k]);
      apb(1'b0, rows[i].idx, 4'h0);
      chk("flags", rows[i].rb, rd);
      apb(1'b1, rows[i].idx, 4'h0);
    end
    $display("event rows done");
    apb(1'b1, `IRQF_IDX_MODE1, 4'h1);
    apb(1'b1, `IRQF_IDX_PINS, 4'h8);
    p1 <= 1'b1;
    tick(4);
    chk("pin1 rise", 0, irq[1]);
    p1 <= 1'b0;
    tick(4);
    chk("pin1 fall", 1, irq[1]);
    go <= 1'b1;
    tick(4);
    go <= 1'b0;
    apb(1'b0, `IRQF_IDX_PINS, 4'h0);
    chk("pin1 acked", 4'h8, rd);
    apb(1'b1, `IRQF_IDX_MODE1, 4'h0);
    p1 <= 1'b1;
    tick(4);
    chk("pin1 rise mode", 1, irq[1]);
    apb(1'b1, `IRQF_IDX_PINS, 4'h2);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `IRQF_IDX_MODE0, 4'(m));
      for (int e = 0; e < 2; e++) begin
        p0 <= ~p0;
        tick(4);
        apb(1'b0, `IRQF_IDX_PINS, 4'h0);
        chk("pin0", {30'h0, 1'b1, (m == 2) || (m == e)}, rd);
        apb(1'b1, `IRQF_IDX_PINS, 4'h2);
      end
    end
    clk_en <= 1'b0;
    apb(1'b1, `IRQF_IDX_MODE0, 4'h8);
    p0 <= 1'b1;
    tick(140);
    apb(1'b0, `IRQF_IDX_PINS, 4'h0);
    chk("pin0 div64", 4'h3, rd);
    // Leaving the pin 0 flag set would make the core take it before the basic timer.
    apb(1'b1, `IRQF_IDX_PINS, 4'h0);
    $display("pin tests done");
    apb(1'b1, `IRQF_IDX_MODEK, 4'h4);
    apb(1'b1, `IRQF_IDX_KEY, 4'h2);
    keys <= 3'h6;
    tick(4);
    chk("key line 0", 0, irq[6]);
    keys <= 3'h2;
    tick(8);
    chk("key line 2", 1, irq[6]);
    apb(1'b1, `IRQF_IDX_KEY, 4'h2);
    chk("key cleared", 0, irq[6]);
    apb(1'b1, `IRQF_IDX_MODEK, 4'h0);
    keys <= 3'h0;
    tick(4);
    chk("keys off", 0, irq[6]);
    apb(1'b1, `IRQF_IDX_PRIO, 4'h0);
    apb(1'b1, `IRQF_IDX_BT, 4'h2);
    pulse(2);
    chk("master off", 0, irq[2]);
    apb(1'b1, `IRQF_IDX_PRIO, 4'h8);
    tick(1);
    chk("master on", 1, irq[2]);
    go <= 1'b1;
    tick(4);
    chk("bt acked", 0, irq[2]);
    apb(1'b0, 12'hfb9, 4'h0);
    chk("unmapped", 1, sl);
    $display("key and master tests done");
    apb(1'b1, `IRQF_IDX_KEY, 4'h3);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    chk("irq after reset", 0, irq);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 4'h0);
      chk("reset value", 0, rd);
    end
    $display("reset test done");
    report_and_stop();
  end

  initial begin
    tick(5000);
    chk("watchdog", 0, 1);
    report_and_stop();
  end
endmodule
